// File: common/dss_consts.svh
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH
// Word length fields hold the length minus one.
`define DSS_WL_MIN      4'h2
`define DSS_WL_TOP      4'hF
`define DSS_SLOT_LAST24 5'h17
`define DSS_SLOT_LAST32 5'h1F
`define DSS_SLOT_RST    5'h00
`define DSS_MU_CLIP     16'h7F7B
`define DSS_MU_BIAS     16'h0084
`define DSS_A_MAG_MAX   16'h7FFF
`define DSS_A_SEG_BASE  16'h0100
`define DSS_A_TOGGLE    8'h55
`define DSS_A_HALF      4'h8
`define DSS_RST_WORD    16'h0000
`define DSS_RST_DIV     16'h0000
`endif

// File: common/dss_pkg.sv
package dss_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_SHIFT = 2'b10
    } dss_sec_state_t;
    typedef enum logic [1:0] {
        CMP_NONE = 2'b00,
        CMP_MU   = 2'b10,
        CMP_A    = 2'b11
    } dss_cmp_t;
endpackage

// File: verilog/dss_buf2.sv
`timescale 1ns/100ps
`include "dss_consts.svh"
// Two-entry buffer; the head word always sits in slot zero, so the
// outgoing data comes straight from a flip-flop.
module dss_buf2 (
    // Clock
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en,
    // Filling side
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [15:0] in_data,
    // Draining side
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [15:0]      out_data
);
    logic [15:0] spare_r;
    logic [1:0]  cnt_r;
    wire         push = in_valid & in_ready;
    wire         pop  = out_valid & out_ready;
    wire [1:0]   cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r     <= 2'h0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= `DSS_RST_WORD;
            spare_r   <= `DSS_RST_WORD;
        end else if (en) begin
            cnt_r     <= cnt_nxt;
            in_ready  <= (cnt_nxt != 2'h2);
            out_valid <= (cnt_nxt != 2'h0);
            if (pop) begin
                out_data <= (cnt_r == 2'h2) ? spare_r : in_data;
            end else if (push && cnt_r == 2'h0) begin
                out_data <= in_data;
            end
            if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop))) begin
                spare_r <= in_data;
            end
        end
    end
endmodule

// File: verilog/dss_top.sv
`timescale 1ns/100ps
`include "dss_consts.svh"
// How it works
// - Separate double-buffered transmit and receive sections.
// - Serial clock internal divider or external pin.
// - Receive framing configured apart from transmit.
// - Frameless, or framed with internal/external sync.
// - Sync polarity invertible, normal or alternate width.
// - Word length three to sixteen bits.
// - Optional A-law or mu-law companding.
// - Each section flags its own word completion.
// - Auto mode streams a buffer, one cycle each.
// - Auto mode flags only after whole buffer.
// - Port a multichannel, 24 or 32 slots.
// - Port b pins become interrupts and flags.
// - Port b keeps its internal clock output.
// - Interrupt inputs edge or level sensitive.
// - Five pins per serial port.
module dss_top (
    // Clock, reset, enable
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Serial pins, bit 0 is port a, bit 1 is port b
    input  wire logic [1:0]       serial_clock_i,
    output wire logic [1:0]       serial_clock_o,
    output wire logic [1:0]       serial_clock_oe,
    input  wire logic [1:0]       tx_frame_sync_i,
    output wire logic [1:0]       tx_frame_sync_o,
    output wire logic [1:0]       tx_frame_sync_oe,
    input  wire logic [1:0]       rx_frame_sync_i,
    output wire logic [1:0]       rx_frame_sync_o,
    output wire logic [1:0]       rx_frame_sync_oe,
    output wire logic [1:0]       tx_data_o,
    output wire logic [1:0]       tx_data_oe,
    input  wire logic [1:0]       rx_data_i,
    // Per-port configuration
    input  wire logic [1:0]       clk_internal,
    input  wire logic [1:0][15:0] clk_div,
    input  wire logic [1:0][3:0]  word_len,
    input  wire logic [1:0][1:0]  compand,
    input  wire logic [1:0]       tx_framed,
    input  wire logic [1:0]       tx_fs_internal,
    input  wire logic [1:0]       tx_fs_invert,
    input  wire logic [1:0]       tx_fs_alt,
    input  wire logic [1:0]       rx_framed,
    input  wire logic [1:0]       rx_fs_internal,
    input  wire logic [1:0]       rx_fs_invert,
    input  wire logic [1:0]       rx_fs_alt,
    input  wire logic [1:0]       tx_auto,
    input  wire logic [1:0][15:0] tx_auto_len,
    input  wire logic [1:0]       rx_auto,
    input  wire logic [1:0][15:0] rx_auto_len,
    // Port a multichannel
    input  wire logic             mc_enable,
    input  wire logic             mc_32slots,
    input  wire logic [31:0]      mc_tx_mask,
    input  wire logic [31:0]      mc_rx_mask,
    // Port b interrupt and flag configuration
    input  wire logic             alt_enable,
    input  wire logic [1:0]       ext_irq_edge,
    input  wire logic [1:0]       ext_irq_ack,
    output wire logic [1:0]       ext_irq_req,
    input  wire logic             flag_output_level,
    output wire logic             flag_input_level,
    // Word streams
    input  wire logic [1:0]       tx_valid,
    output wire logic [1:0]       tx_ready,
    input  wire logic [1:0][15:0] tx_data,
    output wire logic [1:0]       rx_valid,
    input  wire logic [1:0]       rx_ready,
    output wire logic [1:0][15:0] rx_data,
    output wire logic [1:0]       tx_irq,
    output wire logic [1:0]       rx_irq
);
    logic [4:0] mc_slot_r;
    logic [4:0] mc_slot_nxt;

    function automatic logic [7:0] dss_compress(input logic [15:0] x, input logic alaw);
        logic        neg;
        logic [15:0] mag;
        logic [15:0] m;
        logic [2:0]  seg;
        logic [3:0]  man;
        neg = x[15];
        mag = neg ? (~x + 16'h0001) : x;
        if (alaw) begin
            m = mag[15] ? `DSS_A_MAG_MAX : mag;
        end else begin
            m = ((mag > `DSS_MU_CLIP) ? `DSS_MU_CLIP : mag) + `DSS_MU_BIAS;
        end
        seg = 3'h0;
        for (int i = 8; i < 15; i++) begin
            if (m[i]) begin
                seg = 3'(i - 7);
            end
        end
        man = (alaw && seg == 3'h0) ? m[7:4] : 4'(m >> ({1'b0, seg} + 4'h3));
        dss_compress = alaw ? ({~neg, seg, man} ^ `DSS_A_TOGGLE) : ~{neg, seg, man};
    endfunction

    function automatic logic [15:0] dss_expand(input logic [7:0] c, input logic alaw);
        logic [7:0]  d;
        logic [15:0] t;
        d = alaw ? (c ^ `DSS_A_TOGGLE) : ~c;
        if (alaw) begin
            t = {8'h00, d[3:0], `DSS_A_HALF};
            if (d[6:4] != 3'h0) begin
                t = (t + `DSS_A_SEG_BASE) << (d[6:4] - 3'h1);
            end
        end else begin
            t = (({9'h000, d[3:0], 3'h0} + `DSS_MU_BIAS) << d[6:4]) - `DSS_MU_BIAS;
        end
        dss_expand = (d[7] ^ alaw) ? (~t + 16'h0001) : t;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            logic [3:0]  pin_s1_r;
            logic [3:0]  pin_s2_r;
            logic        sclk_d_r;
            logic [15:0] div_cnt_r;
            logic        sclk_int_r;
            logic        sclk_oe_r;
            dss_pkg::dss_sec_state_t tx_st_r;
            dss_pkg::dss_sec_state_t tx_st_nxt;
            dss_pkg::dss_sec_state_t rx_st_r;
            dss_pkg::dss_sec_state_t rx_st_nxt;
            logic [15:0] tx_sh_r;
            logic [3:0]  tx_cnt_r;
            logic        tx_loaded_r;
            logic        tx_fs_act_r;
            logic        tx_fs_o_r;
            logic        tx_fs_oe_r;
            logic        tx_dt_r;
            logic        tx_dt_oe_r;
            logic [15:0] rx_sh_r;
            logic [3:0]  rx_cnt_r;
            logic        rx_pend_r;
            logic [15:0] rx_word_r;
            logic        rx_fs_act_r;
            logic        rx_fs_o_r;
            logic        rx_fs_oe_r;
            logic [15:0] tx_ab_r;
            logic [15:0] rx_ab_r;
            logic        tx_irq_r;
            logic        rx_irq_r;
            logic        txb_valid;
            logic [15:0] txb_data;
            logic        rxb_ready;

            wire alt_on   = (g == 1) && alt_enable;
            wire mc_on    = (g == 0) && mc_enable;
            wire div_hit  = (div_cnt_r == clk_div[g]);
            wire int_rise = div_hit & ~sclk_int_r;
            wire int_fall = div_hit & sclk_int_r;
            wire ext_rise = pin_s2_r[3] & ~sclk_d_r;
            wire ext_fall = ~pin_s2_r[3] & sclk_d_r;
            wire rise_evt = clk_en & (clk_internal[g] ? int_rise : ext_rise);
            wire fall_evt = clk_en & (clk_internal[g] ? int_fall : ext_fall);
            wire [3:0] wl = (word_len[g] < `DSS_WL_MIN) ? `DSS_WL_MIN : word_len[g];
            wire cmp_on   = (compand[g] == dss_pkg::CMP_MU) | (compand[g] == dss_pkg::CMP_A);
            wire cmp_a    = (compand[g] == dss_pkg::CMP_A);

            // Transmit section decode.
            wire tx_fs_gen  = tx_framed[g] & tx_fs_internal[g] & ~mc_on;
            wire tx_fs_ext  = pin_s2_r[2] ^ tx_fs_invert[g];
            wire tx_free    = ~tx_framed[g] | mc_on;
            wire tx_is_sh   = (tx_st_r == dss_pkg::ST_SHIFT);
            wire tx_is_arm  = (tx_st_r == dss_pkg::ST_ARMED);
            wire tx_fin     = rise_evt & tx_is_sh & (tx_cnt_r == 4'h0);
            wire tx_can     = (tx_st_r == dss_pkg::ST_IDLE) | (tx_is_sh & tx_cnt_r == 4'h0);
            wire tx_trig    = tx_free ? (txb_valid | mc_on)
                                      : (tx_fs_internal[g] ? txb_valid : tx_fs_ext);
            wire tx_now     = tx_free | tx_fs_alt[g];
            wire tx_go      = rise_evt & ~alt_on;
            wire tx_start   = tx_go & ((tx_can & tx_trig & tx_now) | tx_is_arm);
            wire tx_arm     = tx_go & tx_can & tx_trig & ~tx_now;
            wire tx_slot_ok = ~mc_on | mc_tx_mask[mc_slot_nxt];
            wire tx_load    = tx_start & txb_valid & tx_slot_ok;
            wire [15:0] tx_word  = cmp_on ? {8'h00, dss_compress(txb_data, cmp_a)} : txb_data;
            wire [15:0] tx_align = tx_word << (`DSS_WL_TOP - wl);
            wire tx_evt     = tx_fin & tx_loaded_r;

            // Receive section decode, framing configured apart from transmit; word length and companding are shared.
            wire rx_fs_gen  = rx_framed[g] & rx_fs_internal[g] & ~mc_on;
            wire rx_fs_seen = rx_fs_internal[g] ? rx_fs_act_r
                                                : (pin_s2_r[1] ^ rx_fs_invert[g]);
            wire rx_free    = ~rx_framed[g] | mc_on;
            wire rx_idle    = (rx_st_r == dss_pkg::ST_IDLE);
            wire rx_go      = fall_evt & ~alt_on & ~rx_pend_r;
            wire rx_start   = rx_go & ((rx_idle & (rx_free | (rx_fs_seen & rx_fs_alt[g])))
                                       | (rx_st_r == dss_pkg::ST_ARMED));
            wire rx_arm     = rx_go & rx_idle & ~rx_free & rx_fs_seen & ~rx_fs_alt[g];
            wire rx_step    = fall_evt & (rx_st_r == dss_pkg::ST_SHIFT);
            wire rx_fin     = rx_step & (rx_cnt_r == 4'h1);
            wire [15:0] rx_in   = {rx_sh_r[14:0], pin_s2_r[0]};
            wire [15:0] rx_word = cmp_on ? dss_expand(rx_in[7:0], cmp_a) : rx_in;
            wire rx_slot_ok = ~mc_on | mc_rx_mask[mc_slot_r];
            wire rx_evt     = rx_pend_r & rxb_ready;

            // Pins cross into the system clock through two flip-flops.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_s1_r <= 4'h0;
                    pin_s2_r <= 4'h0;
                    sclk_d_r <= 1'b0;
                end else if (clk_en) begin
                    pin_s1_r <= {serial_clock_i[g], tx_frame_sync_i[g],
                                 rx_frame_sync_i[g], rx_data_i[g]};
                    pin_s2_r <= pin_s1_r;
                    sclk_d_r <= pin_s2_r[3];
                end
            end

            // The divider runs in every mode so port b still offers its clock.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    div_cnt_r  <= `DSS_RST_DIV;
                    sclk_int_r <= 1'b0;
                    sclk_oe_r  <= 1'b0;
                end else if (clk_en) begin
                    div_cnt_r  <= div_hit ? `DSS_RST_DIV : div_cnt_r + 16'h0001;
                    sclk_int_r <= sclk_int_r ^ div_hit;
                    sclk_oe_r  <= clk_internal[g];
                end
            end

            always_comb begin
                tx_st_nxt = tx_st_r;
                case (tx_st_r)
                    dss_pkg::ST_IDLE:  if (tx_start) tx_st_nxt = dss_pkg::ST_SHIFT;
                                       else if (tx_arm) tx_st_nxt = dss_pkg::ST_ARMED;
                    dss_pkg::ST_ARMED: if (tx_start) tx_st_nxt = dss_pkg::ST_SHIFT;
                    dss_pkg::ST_SHIFT: if (tx_arm) tx_st_nxt = dss_pkg::ST_ARMED;
                                       else if (tx_fin & ~tx_start) tx_st_nxt = dss_pkg::ST_IDLE;
                    default:           tx_st_nxt = dss_pkg::ST_IDLE;
                endcase
                if (alt_on) tx_st_nxt = dss_pkg::ST_IDLE;
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    tx_st_r     <= dss_pkg::ST_IDLE;
                    tx_sh_r     <= `DSS_RST_WORD;
                    tx_cnt_r    <= 4'h0;
                    tx_loaded_r <= 1'b0;
                    tx_fs_act_r <= 1'b0;
                end else if (clk_en) begin
                    tx_st_r <= tx_st_nxt;
                    if (tx_start) begin
                        tx_sh_r     <= tx_load ? tx_align : `DSS_RST_WORD;
                        tx_cnt_r    <= wl;
                        tx_loaded_r <= tx_load;
                    end else if (rise_evt & tx_is_sh & ~tx_fin) begin
                        tx_sh_r  <= tx_sh_r << 1;
                        tx_cnt_r <= tx_cnt_r - 4'h1;
                    end
                    if (rise_evt) begin
                        tx_fs_act_r <= tx_fs_gen & (tx_arm | (tx_fs_alt[g] & (tx_start
                                       | (tx_is_sh & ~tx_fin))));
                    end
                end
            end

            always_comb begin
                rx_st_nxt = rx_st_r;
                case (rx_st_r)
                    dss_pkg::ST_IDLE:  if (rx_start) rx_st_nxt = dss_pkg::ST_SHIFT;
                                       else if (rx_arm) rx_st_nxt = dss_pkg::ST_ARMED;
                    dss_pkg::ST_ARMED: if (rx_start) rx_st_nxt = dss_pkg::ST_SHIFT;
                    dss_pkg::ST_SHIFT: if (rx_fin) rx_st_nxt = dss_pkg::ST_IDLE;
                    default:           rx_st_nxt = dss_pkg::ST_IDLE;
                endcase
                if (alt_on) rx_st_nxt = dss_pkg::ST_IDLE;
            end

            // A full buffer holds the finished word and stalls the next start.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    rx_st_r     <= dss_pkg::ST_IDLE;
                    rx_sh_r     <= `DSS_RST_WORD;
                    rx_cnt_r    <= 4'h0;
                    rx_pend_r   <= 1'b0;
                    rx_word_r   <= `DSS_RST_WORD;
                    rx_fs_act_r <= 1'b0;
                end else if (clk_en) begin
                    rx_st_r <= rx_st_nxt;
                    if (rx_start) begin
                        rx_sh_r  <= {15'h0000, pin_s2_r[0]};
                        rx_cnt_r <= wl;
                    end else if (rx_step) begin
                        rx_sh_r  <= rx_in;
                        rx_cnt_r <= rx_cnt_r - 4'h1;
                    end
                    if (rx_fin) begin
                        rx_pend_r <= rx_slot_ok;
                        rx_word_r <= rx_word;
                    end else if (rx_evt) begin
                        rx_pend_r <= 1'b0;
                    end
                    if (rise_evt) begin
                        rx_fs_act_r <= rx_fs_gen & ~rx_pend_r & (rx_fs_alt[g]
                                       ? ~(rx_st_r == dss_pkg::ST_ARMED) : rx_idle);
                    end
                end
            end

            // Pin drivers.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    tx_fs_o_r  <= 1'b0;
                    tx_fs_oe_r <= 1'b0;
                    rx_fs_o_r  <= 1'b0;
                    rx_fs_oe_r <= 1'b0;
                    tx_dt_r    <= 1'b0;
                    tx_dt_oe_r <= 1'b0;
                end else if (clk_en) begin
                    tx_fs_o_r  <= tx_fs_act_r ^ tx_fs_invert[g];
                    tx_fs_oe_r <= tx_fs_gen & ~alt_on;
                    rx_fs_o_r  <= rx_fs_act_r ^ rx_fs_invert[g];
                    rx_fs_oe_r <= rx_fs_gen & ~alt_on;
                    tx_dt_r    <= alt_on ? flag_output_level : tx_sh_r[15];
                    tx_dt_oe_r <= alt_on | ~mc_on | (tx_loaded_r & tx_is_sh);
                end
            end

            // Word interrupts; auto mode counts words and flags the buffer end.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    tx_ab_r  <= 16'h0000;
                    rx_ab_r  <= 16'h0000;
                    tx_irq_r <= 1'b0;
                    rx_irq_r <= 1'b0;
                end else if (clk_en) begin
                    tx_irq_r <= tx_evt & (~tx_auto[g] | tx_ab_r == tx_auto_len[g]);
                    rx_irq_r <= rx_evt & (~rx_auto[g] | rx_ab_r == rx_auto_len[g]);
                    if (~tx_auto[g]) tx_ab_r <= 16'h0000;
                    else if (tx_evt) tx_ab_r <= (tx_ab_r == tx_auto_len[g]) ? 16'h0000
                                                : tx_ab_r + 16'h0001;
                    if (~rx_auto[g]) rx_ab_r <= 16'h0000;
                    else if (rx_evt) rx_ab_r <= (rx_ab_r == rx_auto_len[g]) ? 16'h0000
                                                : rx_ab_r + 16'h0001;
                end
            end

            dss_buf2 u_txb (
                .clk       (sys_clk),
                .rst       (rst),
                .en        (clk_en),
                .in_valid  (tx_valid[g]),
                .in_ready  (tx_ready[g]),
                .in_data   (tx_data[g]),
                .out_valid (txb_valid),
                .out_ready (tx_load),
                .out_data  (txb_data)
            );
            dss_buf2 u_rxb (
                .clk       (sys_clk),
                .rst       (rst),
                .en        (clk_en),
                .in_valid  (rx_pend_r),
                .in_ready  (rxb_ready),
                .in_data   (rx_word_r),
                .out_valid (rx_valid[g]),
                .out_ready (rx_ready[g]),
                .out_data  (rx_data[g])
            );

            assign serial_clock_o[g]   = sclk_int_r;
            assign serial_clock_oe[g]  = sclk_oe_r;
            assign tx_frame_sync_o[g]  = tx_fs_o_r;
            assign tx_frame_sync_oe[g] = tx_fs_oe_r;
            assign rx_frame_sync_o[g]  = rx_fs_o_r;
            assign rx_frame_sync_oe[g] = rx_fs_oe_r;
            assign tx_data_o[g]        = tx_dt_r;
            assign tx_data_oe[g]       = tx_dt_oe_r;
            assign tx_irq[g]           = tx_irq_r;
            assign rx_irq[g]           = rx_irq_r;

            if (g == 0) begin : g_mc
                // Receive sync at a word start realigns the frame to slot zero.
                wire [4:0] last = mc_32slots ? `DSS_SLOT_LAST32 : `DSS_SLOT_LAST24;
                assign mc_slot_nxt = (rx_fs_seen | mc_slot_r == last) ? `DSS_SLOT_RST
                                     : mc_slot_r + 5'h01;
                always_ff @(posedge sys_clk) begin
                    if (rst) begin
                        mc_slot_r <= `DSS_SLOT_RST;
                    end else if (clk_en & tx_start & mc_on) begin
                        mc_slot_r <= mc_slot_nxt;
                    end
                end
            end else begin : g_alt
                // Interrupt pins are active low; edge requests hold until acknowledged.
                logic [1:0] irq_d_r;
                logic [1:0] irq_r;
                logic       flag_r;
                wire  [1:0] irq_low = ~{pin_s2_r[2], pin_s2_r[1]};
                always_ff @(posedge sys_clk) begin
                    if (rst) begin
                        // Start as asserted, since the synchroniser reads low from reset.
                        irq_d_r <= 2'b11;
                        irq_r   <= 2'b00;
                        flag_r  <= 1'b0;
                    end else if (clk_en) begin
                        irq_d_r <= irq_low;
                        flag_r  <= alt_on & pin_s2_r[0];
                        irq_r   <= {2{alt_on}} & ((ext_irq_edge & ((irq_r & ~ext_irq_ack)
                                   | (irq_low & ~irq_d_r))) | (~ext_irq_edge & irq_low));
                    end
                end
                assign ext_irq_req      = irq_r;
                assign flag_input_level = flag_r;
            end
        end
    endgenerate
endmodule

// File: dv/dss_chk_properties.sv
`timescale 1ns/100ps
module dss_chk (
    // Clock and reset
    input wire logic             sys_clk, rst,
    // Watched pins and streams
    input wire logic             alt_enable, flag_output_level, flag_input_level,
    input wire logic [1:0]       clk_internal, serial_clock_oe, tx_data_o, rx_data_i,
    input wire logic [1:0]       ext_irq_edge, ext_irq_ack, rx_frame_sync_i, ext_irq_req,
    input wire logic [1:0]       rx_valid, rx_ready, rx_irq,
    input wire logic [1:0][15:0] rx_data
);
    wire logic                   lvl0 = alt_enable && !ext_irq_edge[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_coe; !$past(rst) |-> serial_clock_oe == $past(clk_internal); endproperty
    a_coe: assert property (p_coe) else $error("clock oe wrong");
    property p_fo; !$past(rst) && alt_enable |-> tx_data_o[1] == $past(flag_output_level);
    endproperty
    a_fo: assert property (p_fo) else $error("flag out wrong");
    property p_fi; alt_enable && $rose(rx_data_i[1]) |-> ##[1:4] flag_input_level; endproperty
    a_fi: assert property (p_fi) else $error("flag in late");
    property p_lo; (lvl0 && !rx_frame_sync_i[1])[*5] |-> ext_irq_req[0]; endproperty
    a_lo: assert property (p_lo) else $error("level irq missed");
    property p_hi; (lvl0 && rx_frame_sync_i[1])[*5] |-> !ext_irq_req[0]; endproperty
    a_hi: assert property (p_hi) else $error("level irq stuck");
    property p_eh; ext_irq_edge[1] && ext_irq_req[1] && !ext_irq_ack[1] |=> ext_irq_req[1];
    endproperty
    a_eh: assert property (p_eh) else $error("edge irq lost");
    property p_rh; rx_valid[0] && !rx_ready[0] |=> rx_valid[0] && $stable(rx_data[0]);
    endproperty
    a_rh: assert property (p_rh) else $error("rx word not held");
    property p_ri; $rose(rx_valid[0]) |-> rx_irq[0]; endproperty
    a_ri: assert property (p_ri) else $error("rx irq missing");
endmodule
bind dss_top dss_chk u_chk (.*);

// File: dv/dss_far.sv
`timescale 1ns/100ps
// Far end looped back, so sync and data keep the port's own polarity and length.
module dss_far (input wire logic fs_in, dt_in, dt_oe, output wire logic fs_out, dr_out);
    assign fs_out = fs_in;
    // A released line shows the inverse, never a stale copy.
    assign dr_out = dt_oe ? dt_in : ~dt_in;
endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic             sys_clk, rst, clk_en, mc_enable, mc_32slots, alt_enable;
    logic             flag_output_level, rd1;
    logic [1:0]       clk_internal, tx_framed, tx_fs_internal, tx_fs_invert, tx_fs_alt, pin_b;
    logic [1:0]       rx_framed, rx_fs_internal, rx_fs_invert, rx_fs_alt, tx_auto, rx_auto;
    logic [1:0]       ext_irq_edge, ext_irq_ack, tx_valid, rx_ready;
    logic [1:0][1:0]  compand;
    logic [1:0][3:0]  word_len;
    logic [1:0][15:0] clk_div, tx_auto_len, rx_auto_len, tx_data;
    logic [31:0]      mc_tx_mask, mc_rx_mask;
    wire logic        flag_input_level, fs0, dr0;
    wire logic [1:0]  serial_clock_o, serial_clock_oe, tx_frame_sync_o, tx_frame_sync_oe;
    wire logic [1:0]  rx_frame_sync_o, rx_frame_sync_oe, tx_data_o, tx_data_oe, tx_ready;
    wire logic [1:0]  rx_valid, tx_irq, rx_irq, ext_irq_req;
    wire logic [1:0][15:0] rx_data;
    wire logic [1:0]  serial_clock_i = 2'b00;
    wire logic [1:0]  tx_frame_sync_i = {pin_b[1], 1'b0};
    wire logic [1:0]  rx_frame_sync_i = {pin_b[0], fs0};
    wire logic [1:0]  rx_data_i = {rd1, dr0};
    int               err_count, cmp_count, i, irqs;
    dss_top uut (.*);
    dss_far u_far (.fs_in(tx_frame_sync_o[0]), .dt_in(tx_data_o[0]), .dt_oe(tx_data_oe[0]),
        .fs_out(fs0), .dr_out(dr0));
    initial forever #2.5 sys_clk = ~sys_clk;
    // Each word pulses both port a interrupts once, so a loop expects four.
    always @(posedge sys_clk) irqs <= rst ? 0 : irqs + tx_irq[0] + rx_irq[0];
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) err_count++;
        if (s !== e) $display("Error at %0t: seen %h expected %h", $time, s, e);
    endtask
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // The word is left unread a few cycles so the buffer must hold it.
    task take(input logic [15:0] e);
        for (i = 0; i < 3000 && rx_valid[0] !== 1'b1; i++) step(1);
        chk(i < 3000, 1'b1);
        if (i == 3000) end_of_test;
        step(3);
        chk(rx_data[0], e);
        rx_ready[0] = 1;
        step(1);
        rx_ready[0] = 0;
    endtask
    // Config changes only under reset, since a live change could fake a frame start.
    task t_loop(input logic [3:0] wl, input logic inv, input logic [15:0] w0, w1);
        word_len = {wl, wl};
        {tx_fs_invert[0], rx_fs_invert[0]} = {inv, inv};
        rst = 1;
        step(12);
        rst = 0;
        step(1);
        tx_data[0] = w0;
        tx_valid[0] = 1;
        step(1);
        tx_data[0] = w1;
        step(1);
        tx_valid[0] = 0;
        take(w0 & (16'hFFFF >> (4'hF - wl)));
        take(w1 & (16'hFFFF >> (4'hF - wl)));
        step(8);
        chk(irqs, 4);
        chk({tx_ready[0], serial_clock_oe[0], tx_frame_sync_oe[0], rx_frame_sync_oe[0],
             tx_data_oe[0], ext_irq_req[1], tx_frame_sync_o[0], rx_frame_sync_o[0]},
            {6'h3A, inv, inv});
        $display("Loop test done");
    endtask
    task t_pins;
        {flag_output_level, rd1, pin_b[0]} = 3'h6;
        step(6);
        chk({tx_data_o[1], flag_input_level, ext_irq_req[0], serial_clock_oe[1]}, 4'hF);
        i = serial_clock_o[1];
        step(4);
        chk(serial_clock_o[1], !i);
        pin_b = 2'b01;
        step(2);
        pin_b = 2'b11;
        step(6);
        chk(ext_irq_req, 2'b10);
        ext_irq_ack[1] = 1;
        step(1);
        ext_irq_ack[1] = 0;
        step(2);
        chk(ext_irq_req, 2'b00);
        $display("Pin test done");
    endtask
    initial begin
        {sys_clk, mc_enable, mc_32slots, flag_output_level, rd1, tx_fs_alt, rx_fs_alt} = '0;
        {rx_fs_internal, tx_auto, rx_auto, ext_irq_ack, tx_valid, rx_ready, compand} = '0;
        {tx_data, tx_auto_len, rx_auto_len, mc_tx_mask, mc_rx_mask, tx_fs_invert} = '0;
        {clk_en, alt_enable, pin_b, rst, rx_fs_invert, word_len} = '1;
        {clk_internal, tx_framed, tx_fs_internal, rx_framed, ext_irq_edge} = 10'h356;
        clk_div = {16'h0003, 16'h0003};
        t_loop(4'hF, 1'b0, 16'hA5C3, 16'h5A3C);
        t_loop(4'h2, 1'b1, 16'h0005, 16'h0002);
        t_pins;
        end_of_test;
    end
endmodule
